// File: hw/sfl_cmd.v
// Purpose: opcode decoder for latch and block lock commands of a serial flash
// Assumes: SPI mode 0; pins sampled by two flops on i_clk; sclk well below
//          i_clk / 4
// Notes:   Latch, volatile permission and per-block lock bits
// Summary of operation
// RQ1 - Latch and lock commands are dropped unless chip select rises on a byte edge
// RQ2 - Host shifts all command bytes before releasing chip select; the bench cuts a 12-bit and a 30-bit frame
// RQ3 - Complete write disable clears the write enable latch at release
// RQ4 - Program, erase, OTP and status write refused while latch clear
// RQ5 - Write disable and volatile enable are opcode only
// RQ6 - Opcodes are eight clocks, most significant bit first
// RQ7 - Volatile enable allows only the next status write, then lapses
// RQ8 - Volatile enable leaves the write enable latch untouched
// RQ9 - Host sends volatile enable before each status write
// RQ10 - Block locks count only while block protect select is set
// RQ11 - Otherwise protection comes from complement, top/bottom, size, range bits
// RQ12 - All lock bits are one after reset
// RQ13 - Lock and unlock accepted only with the latch set
// RQ14 - Lock opcode is followed by 24 address bits, msb first
// RQ15 - Release after lock or unlock updates the bit, then clears latch
// RQ16 - Unlock clears the addressed block lock bit
// RQ17 - Lock and unlock have no data phase
// RQ18 - Both read lock opcodes decode as one operation
// RQ19 - Host uses read lock only while block protect select is set
// RQ20 - Complete write enable sets the latch at release
// RQ21 - Read lock returns lock state in bit 0, repeated while selected
// RQ22 - Returned bit belongs to the 4 kB region holding the address
// RQ23 - Read lock data leaves on the serial output
`timescale 1ns/1ps
`default_nettype none
`include "sfl_regs.vh"
module sfl_cmd (
    // Clock and reset
    input  wire        i_clk,
    input  wire        i_arst_n,
    // SPI pins
    input  wire        i_cs_n,
    input  wire        i_sclk,
    input  wire        i_si,
    output reg         o_so,
    output reg         o_so_oe_n,
    // Status inputs
    input  wire        i_block_protect_select,
    input  wire        i_protect_complement,
    input  wire        i_top_bottom_select,
    input  wire        i_sector_granule_select,
    input  wire [2:0]  i_protect_range_bits,
    // Status outputs
    output reg         o_write_enable_latch,
    output reg         o_volatile_write_ok,
    // Write gate towards program, erase and status write engines
    output reg         o_write_cmd_ok,
    output reg         o_write_cmd_refused,
    output reg         o_vol_status_write,
    // Protection query for the array engine
    input  wire [23:0] i_query_addr,
    output reg         o_query_protected
);
    // Sync states
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_SHIFT = 3'b010;
    localparam [2:0] ST_OUT = 3'b100;

    reg [1:0]  cs_sync;
    reg [1:0]  ck_sync;
    reg [1:0]  si_sync;
    reg        ck_prev;
    reg [2:0]  state;
    reg [5:0]  bit_cnt;
    reg [31:0] shreg;
    reg [7:0]  opcode;
    reg [2:0]  out_bit;
    reg [`SFL_NBLK-1:0] lock;
    wire       cs_n = cs_sync[1];
    wire       ck_rise = ck_sync[1] & ~ck_prev;
    wire       ck_fall = ~ck_sync[1] & ck_prev;
    wire [31:0] next_shreg = {shreg[30:0], si_sync[1]};
    wire       byte_ok = (bit_cnt[2:0] == 3'h0);
    wire [6:0] cmd_blk = shreg[`SFL_BLK_MSB:`SFL_BLK_LSB];
    wire       rd_lock = lock[cmd_blk];

    // Opcodes that need the latch
    function is_write_op;
        input [7:0] op;
        begin
            case (op)
                `SFL_OP_PROG, `SFL_OP_PROG_D, `SFL_OP_PROG_Q,
                `SFL_OP_SEQ_A, `SFL_OP_SEQ_B, `SFL_OP_ER4K,
                `SFL_OP_ER32K, `SFL_OP_ER64K, `SFL_OP_ERCH_A,
                `SFL_OP_ERCH_B, `SFL_OP_OTP, `SFL_OP_WRSR1,
                `SFL_OP_WRSR2, `SFL_OP_WRSR3, `SFL_OP_WRSR4:
                    is_write_op = 1'b1;
                default: is_write_op = 1'b0;
            endcase
        end
    endfunction

    function is_wrsr;
        input [7:0] op;
        begin
            is_wrsr = (op == `SFL_OP_WRSR1) || (op == `SFL_OP_WRSR2) ||
                      (op == `SFL_OP_WRSR3) || (op == `SFL_OP_WRSR4);
        end
    endfunction

    // Range protection: size 32 kB or 4 kB granules from the top or bottom
    function range_hit;
        input [23:0] a;
        input        tb;
        input        sec;
        input        cmpl;
        input [2:0]  bp;
        reg   [6:0]  blk;
        reg   [6:0]  span;
        reg          hit;
        begin
            blk = a[`SFL_BLK_MSB:`SFL_BLK_LSB];
            if (bp == 3'h0)
                span = 7'h00;
            else if (sec)
                span = (bp[2] ? 7'h08 : (7'h01 << (bp[1:0] - 2'h1)));
            else
                span = (bp == 3'h7) ? 7'h7F : (7'h08 << (bp - 3'h1));
            hit = tb ? (blk < span) : ({1'b0, blk} >= (8'h80 - {1'b0, span}));
            if (bp == 3'h7 && !sec)
                hit = 1'b1;
            range_hit = hit ^ cmpl; // RQ11
        end
    endfunction

    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cs_sync <= 2'h3;
            ck_sync <= 2'h0;
            si_sync <= 2'h0;
            ck_prev <= 1'b0;
        end else begin
            // First stages feed only the second stages
            cs_sync <= {cs_sync[0], i_cs_n};
            ck_sync <= {ck_sync[0], i_sclk};
            si_sync <= {si_sync[0], i_si};
            ck_prev <= ck_sync[1];
        end
    end

    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state <= ST_IDLE;
            bit_cnt <= 6'h00;
            shreg <= 32'h0000_0000;
            opcode <= 8'h00;
            out_bit <= 3'h0;
            lock <= {`SFL_NBLK{`SFL_LOCK_RST}}; // RQ12
            o_write_enable_latch <= `SFL_LATCH_RST;
            o_volatile_write_ok <= 1'b0;
            o_write_cmd_ok <= 1'b0;
            o_write_cmd_refused <= 1'b0;
            o_vol_status_write <= 1'b0;
            o_so <= 1'b0;
            o_so_oe_n <= 1'b1;
            o_query_protected <= 1'b1;
        end else begin
            o_write_cmd_ok <= 1'b0;
            o_write_cmd_refused <= 1'b0;
            o_vol_status_write <= 1'b0;
            // Lock bits apply only with block select; else range fields
            o_query_protected <= i_block_protect_select ?
                lock[i_query_addr[`SFL_BLK_MSB:`SFL_BLK_LSB]] : // RQ10
                range_hit(i_query_addr, i_top_bottom_select,
                          i_sector_granule_select, i_protect_complement,
                          i_protect_range_bits); // RQ11
            case (state)
                ST_IDLE: begin
                    o_so_oe_n <= 1'b1;
                    bit_cnt <= 6'h00;
                    if (!cs_n)
                        state <= ST_SHIFT;
                end
                ST_SHIFT: begin
                    if (cs_n) begin
                        state <= ST_IDLE;
                        // Release: act only on whole-byte frames
                        if (byte_ok && bit_cnt == `SFL_OP_BITS) begin // RQ1
                            case (opcode)
                                `SFL_OP_WRDI: // RQ5
                                    o_write_enable_latch <= 1'b0; // RQ3
                                `SFL_OP_WREN:
                                    o_write_enable_latch <= 1'b1; // RQ20
                                `SFL_OP_VWREN:
                                    o_volatile_write_ok <= 1'b1; // RQ8
                                default: ;
                            endcase
                        end
                        if (bit_cnt == `SFL_CMD_BITS &&
                            o_write_enable_latch) begin // RQ13 RQ17
                            if (opcode == `SFL_OP_BLOCK) begin
                                lock[cmd_blk] <= 1'b1; // RQ15
                                o_write_enable_latch <= 1'b0; // RQ15
                            end else if (opcode == `SFL_OP_UNBLOCK) begin
                                lock[cmd_blk] <= 1'b0; // RQ16
                                o_write_enable_latch <= 1'b0; // RQ15
                            end
                        end
                    end else if (ck_rise) begin
                        shreg <= next_shreg; // RQ6 RQ14
                        if (bit_cnt != 6'h3F)
                            bit_cnt <= bit_cnt + 6'h01;
                        if (bit_cnt == `SFL_OP_BITS - 6'h01) begin
                            opcode <= next_shreg[7:0];
                            if (is_write_op(next_shreg[7:0])) begin
                                // Gate only; the engine honours latch state
                                o_write_cmd_ok <= o_write_enable_latch;
                                o_write_cmd_refused <=
                                    ~o_write_enable_latch; // RQ4
                                if (is_wrsr(next_shreg[7:0])) begin
                                    o_vol_status_write <=
                                        o_volatile_write_ok; // RQ7
                                    o_volatile_write_ok <= 1'b0; // RQ7
                                end
                            end
                        end
                        if (bit_cnt == `SFL_CMD_BITS - 6'h01 &&
                            (opcode == `SFL_OP_RDLOCK_A ||
                             opcode == `SFL_OP_RDLOCK_B)) begin // RQ18
                            out_bit <= 3'h7;
                            state <= ST_OUT;
                        end
                    end
                end
                ST_OUT: begin
                    if (cs_n) begin
                        state <= ST_IDLE;
                        o_so_oe_n <= 1'b1;
                    end else if (ck_fall) begin
                        o_so_oe_n <= 1'b0; // RQ23
                        // Upper bits read as zero; byte repeats
                        o_so <= (out_bit == 3'h0) ? rd_lock : 1'b0; // RQ21 RQ22
                        out_bit <= out_bit - 3'h1;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// File: hw/sfl_regs.vh
// Purpose: constants for the serial flash latch and block lock decoder
// Assumes: 100 MHz system clock, SPI mode 0 sampling
// Notes:   4 kB regions, 4 Mbit array gives 128 lock bits
`ifndef SFL_REGS_VH
`define SFL_REGS_VH
`define SFL_OP_WREN     8'h06
`define SFL_OP_WRDI     8'h04
`define SFL_OP_VWREN    8'h50
`define SFL_OP_BLOCK    8'h36
`define SFL_OP_UNBLOCK  8'h39
`define SFL_OP_RDLOCK_A 8'h3C
`define SFL_OP_RDLOCK_B 8'h3D
`define SFL_OP_PROG     8'h02
`define SFL_OP_PROG_D   8'hA2
`define SFL_OP_PROG_Q   8'h32
`define SFL_OP_SEQ_A    8'hAF
`define SFL_OP_SEQ_B    8'hAD
`define SFL_OP_ER4K     8'h20
`define SFL_OP_ER32K    8'h52
`define SFL_OP_ER64K    8'hD8
`define SFL_OP_ERCH_A   8'h60
`define SFL_OP_ERCH_B   8'hC7
`define SFL_OP_OTP      8'h9B
`define SFL_OP_WRSR1    8'h01
`define SFL_OP_WRSR2    8'h31
`define SFL_OP_WRSR3    8'h11
`define SFL_OP_WRSR4    8'h71
`define SFL_OP_BITS     6'd8
`define SFL_CMD_BITS    6'd32
`define SFL_NBLK        128
`define SFL_BLK_MSB     18
`define SFL_BLK_LSB     12
`define SFL_LATCH_RST   1'b0
`define SFL_LOCK_RST    1'b1
`endif

// File: bench/sfl_cmd_props.sv
// Purpose: property checker for the latch and block lock decoder
// Assumes: one clock domain, pins seen through two flops
// Notes:   action bounds allow for the chip select synchroniser
`timescale 1ns/1ps
`default_nettype none
module sfl_cmd_chk (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_arst_n,
    // Watched ports
    input wire logic i_cs_n,
    input wire logic o_so_oe_n,
    input wire logic o_write_enable_latch,
    input wire logic o_volatile_write_ok,
    input wire logic o_write_cmd_ok,
    input wire logic o_write_cmd_refused,
    input wire logic o_vol_status_write
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);
    AST_WEL_SET: assert property (
        $rose(o_write_enable_latch) |-> $past(i_cs_n, 2) && i_cs_n)
        else $error("latch set inside a frame");
    AST_WEL_CLR: assert property (
        $fell(o_write_enable_latch) |-> $past(i_cs_n, 2) && i_cs_n)
        else $error("latch cleared inside a frame");
    AST_VOK_CS: assert property (
        $rose(o_volatile_write_ok) |-> $past(i_cs_n, 2) && i_cs_n)
        else $error("volatile permission inside a frame");
    AST_VOK_KEEP: assert property (
        $rose(o_volatile_write_ok) |-> $stable(o_write_enable_latch))
        else $error("volatile enable moved the latch");
    AST_REFUSE: assert property (
        o_write_cmd_refused |-> !o_write_enable_latch && !o_write_cmd_ok)
        else $error("refusal with latch set");
    AST_ALLOW: assert property (
        o_write_cmd_ok |-> o_write_enable_latch)
        else $error("write accepted with latch clear");
    AST_ONE_SHOT: assert property (
        o_vol_status_write |-> $past(o_volatile_write_ok)
        ##2 !o_volatile_write_ok)
        else $error("volatile permission did not lapse");
    AST_SO_OFF: assert property (
        i_cs_n [*6] |-> o_so_oe_n)
        else $error("serial out driven while idle");
    cover property ($rose(o_write_enable_latch));
    cover property (o_vol_status_write);
    cover property (o_write_cmd_refused);
endmodule
bind sfl_cmd sfl_cmd_chk u_chk (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_cs_n(i_cs_n),
    .o_so_oe_n(o_so_oe_n), .o_write_enable_latch(o_write_enable_latch),
    .o_volatile_write_ok(o_volatile_write_ok),
    .o_write_cmd_ok(o_write_cmd_ok),
    .o_write_cmd_refused(o_write_cmd_refused),
    .o_vol_status_write(o_vol_status_write));
`default_nettype wire

// File: bench/sfl_host.sv
// Purpose: SPI host model driving the decoder
// Assumes: mode 0, 80 ns serial clock parked low between frames
// Notes:   data line has no pull, so it flips after each frame
`timescale 1ns/1ps
`default_nettype none
module sfl_host (
    // SPI pins
    output var logic o_cs_n,
    output var logic o_sclk,
    output var logic o_si,
    input  wire logic i_so
);
    initial begin
        o_cs_n = 1'h1;
        o_sclk = 1'h0;
        o_si = 1'h0;
    end
    // Bits msb first; caller picks whole or cut frames
    task automatic xfer(input logic [47:0] d, input int n,
                        output logic [7:0] rd);
        rd = 8'h00;
        o_cs_n = 1'h0;
        for (int k = 0; k < n; k++) begin
            o_si = d[47 - k];
            #40 o_sclk = 1'h1;
            #40 rd = {rd[6:0], i_so};
            o_sclk = 1'h0;
        end
        #40 o_cs_n = 1'h1;
        o_si = ~o_si;
        #80;
    endtask
endmodule
`default_nettype wire

// File: bench/sfl_cmd_bench.sv
// Purpose: self-checking bench for the latch and block lock decoder
// Assumes: block protect select mostly set, range bits held clear
// Notes:   latch and lock bits mirrored in a small model
`timescale 1ns/1ps
`default_nettype none
module sfl_cmd_bench;
    logic        clk = 0;
    logic        rst_n = 0;
    logic [23:0] qa = 0;
    logic [31:0] s = 32'h0000BE25;
    logic        lk [128];
    logic        wm = 0;
    logic        vm = 0;
    logic [7:0]  r;
    logic        bps = 1;
    logic        cmpl = 0;
    int          num_errors = 0;
    int          compares = 0;
    int          n_ok = 0, n_ref = 0, n_vsw = 0;
    int          e_ok = 0, e_ref = 0, e_vsw = 0;
    wire         cs_n, sclk, si, so, oe_n, write_enable_latch, vok, qp;
    wire         wok, wref, vsw;
    sfl_cmd dut (
        .i_clk(clk), .i_arst_n(rst_n), .i_cs_n(cs_n), .i_sclk(sclk),
        .i_si(si), .o_so(so), .o_so_oe_n(oe_n),
        .i_block_protect_select(bps), .i_protect_complement(cmpl),
        .i_top_bottom_select(1'h0), .i_sector_granule_select(1'h0),
        .i_protect_range_bits(3'h0), .o_write_enable_latch(write_enable_latch),
        .o_volatile_write_ok(vok), .o_write_cmd_ok(wok),
        .o_write_cmd_refused(wref), .o_vol_status_write(vsw),
        .i_query_addr(qa), .o_query_protected(qp));
    sfl_host u_host (.o_cs_n(cs_n), .o_sclk(sclk), .o_si(si), .i_so(so));
    initial forever #5 clk = ~clk;
    // Pulses last one cycle, so count them as they pass
    always @(posedge clk) begin
        if (rst_n) begin
            n_ok += wok;
            n_ref += wref;
            n_vsw += vsw;
        end
    end
    function logic [23:0] rnd();
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s[23:0];
    endfunction
    task chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task x(input logic [7:0] c, input logic [23:0] a, input int n);
        u_host.xfer({c, a, 16'h0}, n, r);
    endtask
    task st(input logic [23:0] a);
        qa = a;
        bps = s[0] | s[5];
        cmpl = s[9];
        repeat (2) @(negedge clk);
        chk(8'(write_enable_latch), 8'(wm));
        chk(8'(vok), 8'(vm));
        chk(8'(qp), 8'(bps ? lk[a[18:12]] : cmpl));
        chk(8'(oe_n), 8'h01);
        chk(8'(n_ok), 8'(e_ok));
        chk(8'(n_ref), 8'(e_ref));
        chk(8'(n_vsw), 8'(e_vsw));
        bps = 1;
        $display("test done at %0t", $time);
    endtask
    task stop_test;
        $display("compares=%0d num_errors=%0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        logic [23:0] a;
        logic [7:0]  c;
        logic        en;
        foreach (lk[i]) lk[i] = 1'h1;
        repeat (5) @(negedge clk);
        rst_n = 1;
        repeat (4) @(negedge clk);
        st(rnd());
        x(8'h06, 24'h0, 8);
        wm = 1;
        st(rnd());
        x(8'h02, 24'h0, 8);
        e_ok++;
        x(8'h04, 24'h0, 12);
        st(rnd());
        x(8'h04, 24'h0, 8);
        wm = 0;
        st(rnd());
        x(8'h50, 24'h0, 8);
        vm = 1;
        st(rnd());
        x(8'h01, 24'h0, 8);
        vm = 0;
        e_ref++;
        e_vsw++;
        st(rnd());
        x(8'h02, 24'h0, 8);
        e_ref++;
        for (int i = 0; i < 16; i++) begin
            a = rnd();
            c = (i % 4 < 2) ? 8'h39 : 8'h36;
            en = a[0] | (i < 2);
            if (en) x(8'h06, 24'h0, 8);
            x(c, a, (i == 15) ? 30 : 32);
            if (en && i != 15) lk[a[18:12]] = (c == 8'h36);
            wm = en && i == 15;
            st(a);
            x(a[1] ? 8'h3C : 8'h3D, {a[23:12], 12'(rnd())}, 48);
            chk(r, 8'(lk[a[18:12]]));
        end
        stop_test;
    end
    initial begin
        #400000;
        num_errors++;
        stop_test;
    end
endmodule
`default_nettype wire
